// File: rtl/dpbr_top.v
// dual-port 18 kbit memory block with configurable port widths
`timescale 1ns/1ps
`include "dpbr_defs.vh"
module dpbr_top (
   input  wire        clk_i,                   // system clock
   input  wire        rst_n_i,                 // async reset, low
   // port a pins
   input  wire        a_port_clk_i,            // port a clock
   input  wire        a_en_i,                  // port a enable
   input  wire        a_we_i,                  // port a write enable
   input  wire        a_sync_output_set_reset_i, // port a out preset
   input  wire [13:0] a_addr_i,                // port a address
   input  wire [31:0] a_write_data_in_i,       // port a write data
   input  wire [3:0]  a_write_par_in_i,        // port a write parity
   output reg  [31:0] a_read_data_o,           // port a read data
   output reg  [3:0]  a_read_par_o,            // port a read parity
   // port a configuration
   input  wire [2:0]  a_width_i,               // port a width code
   input  wire [1:0]  a_write_mode_i,          // port a write mode
   input  wire [35:0] a_output_preset_value_i, // port a preset
   input  wire        a_inv_clk_i,             // a falling edge
   input  wire        a_inv_en_i,              // a enable low
   input  wire        a_inv_we_i,              // a write low
   input  wire        a_inv_preset_i,          // a preset low
   // port b pins
   input  wire        b_port_clk_i,            // port b clock
   input  wire        b_en_i,                  // port b enable
   input  wire        b_we_i,                  // port b write enable
   input  wire        b_sync_output_set_reset_i, // port b out preset
   input  wire [13:0] b_addr_i,                // port b address
   input  wire [31:0] b_write_data_in_i,       // port b write data
   input  wire [3:0]  b_write_par_in_i,        // port b write parity
   output reg  [31:0] b_read_data_o,           // port b read data
   output reg  [3:0]  b_read_par_o,            // port b read parity
   // port b configuration
   input  wire [2:0]  b_width_i,               // port b width code
   input  wire [1:0]  b_write_mode_i,          // port b write mode
   input  wire [35:0] b_output_preset_value_i, // port b preset
   input  wire        b_inv_clk_i,             // b falling edge
   input  wire        b_inv_en_i,              // b enable low
   input  wire        b_inv_we_i,              // b write low
   input  wire        b_inv_preset_i           // b preset low
);

   // shared storage, parity in the top four bits of each word
   reg  [35:0] mem [0:511];

   wire        a_act;
   wire        a_wr;
   wire        a_preset;
   wire        b_act;
   wire        b_wr;
   wire        b_preset;
   wire [8:0]  a_idx;
   wire [8:0]  b_idx;
   wire [35:0] a_old;
   wire [35:0] b_old;
   wire [35:0] b_base;
   wire [35:0] a_mask;
   wire [35:0] b_mask;
   wire [35:0] a_new;
   wire [35:0] b_new;
   reg  [35:0] next_a_out;
   reg  [35:0] next_b_out;

   // word index from address; narrow widths stop at word 511
   function [8:0] fn_idx;
      input [2:0]  mode;
      input [13:0] addr;
      begin
         case (mode)
            `DPBR_W1:  fn_idx = addr[13:5];
            `DPBR_W2:  fn_idx = addr[12:4];
            `DPBR_W4:  fn_idx = addr[11:3];
            `DPBR_W9:  fn_idx = addr[10:2];
            `DPBR_W18: fn_idx = addr[9:1];
            default:   fn_idx = addr[8:0];
         endcase
      end
   endfunction

   // bits of the word touched; narrow widths never touch parity
   function [35:0] fn_mask;
      input [2:0]  mode;
      input [13:0] addr;
      begin
         case (mode)
            `DPBR_W1:  fn_mask = 36'h000000001 << addr[4:0];
            `DPBR_W2:  fn_mask = 36'h000000003 << {addr[3:0], 1'b0};
            `DPBR_W4:  fn_mask = 36'h00000000f << {addr[2:0], 2'h0};
            `DPBR_W9:  fn_mask = (36'h0000000ff << {addr[1:0], 3'h0}) |
                                 (36'h100000000 << addr[1:0]);
            `DPBR_W18: fn_mask = (36'h00000ffff << {addr[0], 4'h0}) |
                                 (36'h300000000 << {addr[0], 1'b0});
            default:   fn_mask = 36'hfffffffff;
         endcase
      end
   endfunction

   // write data replicated over every lane, mask picks one
   function [35:0] fn_place;
      input [2:0]  mode;
      input [31:0] d;
      input [3:0]  p;
      begin
         case (mode)
            `DPBR_W1:  fn_place = {4'h0, {32{d[0]}}};
            `DPBR_W2:  fn_place = {4'h0, {16{d[1:0]}}};
            `DPBR_W4:  fn_place = {4'h0, {8{d[3:0]}}};
            `DPBR_W9:  fn_place = {{4{p[0]}}, {4{d[7:0]}}};
            `DPBR_W18: fn_place = {{2{p[1:0]}}, {2{d[15:0]}}};
            default:   fn_place = {p, d};
         endcase
      end
   endfunction

   // selected lane of a word, as {parity, data} right aligned
   function [35:0] fn_pick;
      input [2:0]  mode;
      input [13:0] addr;
      input [35:0] w;
      begin
         case (mode)
            `DPBR_W1:  fn_pick = {35'h0, w[addr[4:0]]};
            `DPBR_W2:  fn_pick = {34'h0, w[{addr[3:0], 1'b0} +: 2]};
            `DPBR_W4:  fn_pick = {32'h0, w[{addr[2:0], 2'h0} +: 4]};
            `DPBR_W9:  fn_pick = {3'h0, w[6'd32 + {4'h0, addr[1:0]}],
                                  24'h0, w[{addr[1:0], 3'h0} +: 8]};
            `DPBR_W18: fn_pick = {2'h0,
                                  w[6'd32 + {4'h0, addr[0], 1'b0} +: 2],
                                  16'h0, w[{addr[0], 4'h0} +: 16]};
            default:   fn_pick = w;
         endcase
      end
   endfunction

   // edge and polarity handling, one per port
   dpbr_ctl u_ctl_a (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .port_clk_i (a_port_clk_i),
      .en_i       (a_en_i),
      .we_i       (a_we_i),
      .preset_i   (a_sync_output_set_reset_i),
      .inv_clk_i  (a_inv_clk_i),
      .inv_en_i   (a_inv_en_i),
      .inv_we_i   (a_inv_we_i),
      .inv_preset_i(a_inv_preset_i),
      .act_o      (a_act),
      .wr_o       (a_wr),
      .preset_o   (a_preset)
   );

   dpbr_ctl u_ctl_b (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .port_clk_i (b_port_clk_i),
      .en_i       (b_en_i),
      .we_i       (b_we_i),
      .preset_i   (b_sync_output_set_reset_i),
      .inv_clk_i  (b_inv_clk_i),
      .inv_en_i   (b_inv_en_i),
      .inv_we_i   (b_inv_we_i),
      .inv_preset_i(b_inv_preset_i),
      .act_o      (b_act),
      .wr_o       (b_wr),
      .preset_o   (b_preset)
   );

   // address decode, each port with its own width setting
   assign a_idx  = fn_idx(a_width_i, a_addr_i);
   assign b_idx  = fn_idx(b_width_i, b_addr_i);
   assign a_mask = fn_mask(a_width_i, a_addr_i);
   assign b_mask = fn_mask(b_width_i, b_addr_i);
   assign a_old  = mem[a_idx];
   assign b_old  = mem[b_idx];

   // merged words; b builds on a when a writes the word b addresses
   assign b_base = (a_wr && (a_idx == b_idx)) ? a_new : b_old;
   assign a_new  = (a_old & ~a_mask) |
                   (fn_place(a_width_i, a_write_data_in_i,
                             a_write_par_in_i) & a_mask);
   assign b_new  = (b_base & ~b_mask) |
                   (fn_place(b_width_i, b_write_data_in_i,
                             b_write_par_in_i) & b_mask);

   // array update; memory has no reset, disabled port leaves it
   always @(posedge clk_i) begin
      if (a_wr) begin
         mem[a_idx] <= a_new;
      end
      if (b_wr) begin
         mem[b_idx] <= b_new;
      end
   end

   // port a output value at an active edge
   always @* begin
      next_a_out = {a_read_par_o, a_read_data_o};
      if (a_preset) begin
         next_a_out = a_output_preset_value_i;
      end else if (!a_wr) begin
         next_a_out = fn_pick(a_width_i, a_addr_i, a_old);
      end else begin
         case (a_write_mode_i)
            `DPBR_WR_FIRST: next_a_out = fn_pick(a_width_i, a_addr_i,
                                                 a_new);
            `DPBR_RD_FIRST: next_a_out = fn_pick(a_width_i, a_addr_i,
                                                 a_old);
            default:        next_a_out = {a_read_par_o, a_read_data_o};
         endcase
      end
   end

   // port b output value at an active edge
   always @* begin
      next_b_out = {b_read_par_o, b_read_data_o};
      if (b_preset) begin
         next_b_out = b_output_preset_value_i;
      end else if (!b_wr) begin
         next_b_out = fn_pick(b_width_i, b_addr_i, b_old);
      end else begin
         case (b_write_mode_i)
            `DPBR_WR_FIRST: next_b_out = fn_pick(b_width_i, b_addr_i,
                                                 b_base & ~b_mask |
                                                 b_new & b_mask);
            `DPBR_RD_FIRST: next_b_out = fn_pick(b_width_i, b_addr_i,
                                                 b_old);
            default:        next_b_out = {b_read_par_o, b_read_data_o};
         endcase
      end
   end

   // output registers load only on an enabled active edge
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {a_read_par_o, a_read_data_o} <= `DPBR_OUT_RST;
         {b_read_par_o, b_read_data_o} <= `DPBR_OUT_RST;
      end else begin
         if (a_act) begin
            {a_read_par_o, a_read_data_o} <= next_a_out;
         end
         if (b_act) begin
            {b_read_par_o, b_read_data_o} <= next_b_out;
         end
      end
   end

endmodule // dpbr_top

// File: rtl/dpbr_defs.vh
// constants shared by the dual-port block memory design
//
// Contract
// - one shared array, two independently timed ports
// - both ports offer identical features
// - each port: clock, enable, write, reset, address, data
// - control input polarities chosen by configuration
// - inputs sampled only on selected clock edge
// - read output changes only on active edge
// - narrow widths reach only sixteen kilobit part
// - parity bits behave exactly as data bits
// - write and read bus share one width
// - each port width chosen independently
// - write loads new, old or no data
// - output set/reset loads per-port preset value
// - enable gates read, write and set/reset
`ifndef DPBR_DEFS_VH
`define DPBR_DEFS_VH

// storage geometry: 512 words of 32 data plus 4 parity bits
`define DPBR_DEPTH       512
`define DPBR_IDX_W       9
`define DPBR_WORD_W      36
`define DPBR_DATA_W      32
`define DPBR_PAR_W       4
`define DPBR_ADDR_W      14

// port width settings
`define DPBR_W1          3'h0
`define DPBR_W2          3'h1
`define DPBR_W4          3'h2
`define DPBR_W9          3'h3
`define DPBR_W18         3'h4
`define DPBR_W36         3'h5

// behaviour of the output register during a write
`define DPBR_WR_FIRST    2'h0
`define DPBR_RD_FIRST    2'h1
`define DPBR_NO_CHANGE   2'h2

// output register value held under reset
`define DPBR_OUT_RST     36'h000000000

`endif

// File: rtl/dpbr_ctl.v
// per-port edge detection and control polarity handling
`timescale 1ns/1ps
module dpbr_ctl (
   input  wire clk_i,       // system clock
   input  wire rst_n_i,     // async reset, active low
   input  wire port_clk_i,  // port clock pin, sampled
   input  wire en_i,        // port enable pin
   input  wire we_i,        // port write enable pin
   input  wire preset_i,    // sync output set/reset pin
   input  wire inv_clk_i,   // high: falling edge is active
   input  wire inv_en_i,    // high: enable active low
   input  wire inv_we_i,    // high: write enable active low
   input  wire inv_preset_i, // high: set/reset active low
   output wire act_o,       // active edge with port enabled
   output wire wr_o,        // write on this edge
   output wire preset_o     // output preset on this edge
);

   reg  clk_prev;
   wire clk_lvl;
   wire edge_hit;

   // polarity-adjusted clock; rising of it is the active edge
   assign clk_lvl = port_clk_i ^ inv_clk_i;

   // previous level starts high so release gives no false edge
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_prev <= 1'b1;
      end else begin
         clk_prev <= clk_lvl;
      end
   end

   // controls count only at the active edge and with enable
   assign edge_hit = clk_lvl & ~clk_prev;
   assign act_o    = edge_hit & (en_i ^ inv_en_i);
   assign wr_o     = act_o & (we_i ^ inv_we_i);
   assign preset_o = act_o & (preset_i ^ inv_preset_i);

endmodule // dpbr_ctl

// File: test/dpbr_props.sv
// port a assertions for the dual-port memory block
`timescale 1ns/1ps
`include "dpbr_defs.vh"
module dpbr_props (
   input wire        clk_i, // clock
   input wire        rst_n_i, // reset, low
   input wire        a_port_clk_i, // clock pin
   input wire        a_en_i, // enable
   input wire        a_we_i, // write
   input wire        a_sync_output_set_reset_i, // preset
   input wire [13:0] a_addr_i, // address
   input wire [31:0] a_write_data_in_i, // data in
   input wire [3:0]  a_write_par_in_i, // parity in
   input wire [2:0]  a_width_i, // width
   input wire [1:0]  a_write_mode_i, // mode
   input wire [35:0] a_output_preset_value_i, // preset word
   input wire        a_inv_clk_i, // clock inv
   input wire        a_inv_en_i, // enable inv
   input wire        a_inv_we_i, // write inv
   input wire        a_inv_preset_i, // preset inv
   input wire [31:0] a_read_data_o, // data out
   input wire [3:0]  a_read_par_o // parity out
);
   reg         prev; // last port clock level
   wire        lvl = a_port_clk_i ^ a_inv_clk_i;
   wire        edg = lvl & ~prev;
   wire        act = edg & (a_en_i ^ a_inv_en_i);
   wire        pre = a_sync_output_set_reset_i ^ a_inv_preset_i;
   wire        wr = act & ~pre & (a_we_i ^ a_inv_we_i);
   wire        rd = act & ~pre & ~(a_we_i ^ a_inv_we_i);
   wire [35:0] q = {a_read_par_o, a_read_data_o};
   wire [35:0] wd = {a_write_par_in_i, a_write_data_in_i};
   // edge detector, high at reset so no edge at release
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         prev <= 1'b1;
      else
         prev <= lvl;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   out_hold_a: assert property (!act |=> $stable(q))
      else $error("output moved without an enabled edge");
   off_gate_a: assert property (edg && !act && pre |=> $stable(q))
      else $error("disabled preset changed the output");
   preset_load_a: assert property (
      act && pre |=> q == $past(a_output_preset_value_i))
      else $error("preset value not loaded");
   keep_out_a: assert property (
      wr && a_write_mode_i == `DPBR_NO_CHANGE |=> $stable(q))
      else $error("no-change write moved the output");
   wr_first_a: assert property (
      wr && a_write_mode_i == `DPBR_WR_FIRST && a_width_i == `DPBR_W36
      |=> q == $past(wd))
      else $error("write-first output not the written word");
   bit_read_a: assert property (
      rd && a_width_i == `DPBR_W1 |=> q[35:1] == 35'h0)
      else $error("one-bit read has upper bits set");
   byte_read_a: assert property (
      rd && a_width_i == `DPBR_W9 |=> q[35:33] == 3'h0 && q[31:8] == 24'h0)
      else $error("byte read has upper bits set");
   half_read_a: assert property (
      rd && a_width_i == `DPBR_W18 |=> q[35:34] == 2'h0 && q[31:16] == 16'h0)
      else $error("half word read has upper bits set");
   cover property (act && pre);
   cover property (wr && a_write_mode_i == `DPBR_NO_CHANGE);
   cover property (rd && a_width_i == `DPBR_W1);
endmodule // dpbr_props

bind dpbr_top dpbr_props i_dpbr_props (
   .clk_i, .rst_n_i, .a_port_clk_i, .a_en_i, .a_we_i,
   .a_sync_output_set_reset_i, .a_addr_i, .a_write_data_in_i,
   .a_write_par_in_i, .a_width_i, .a_write_mode_i, .a_output_preset_value_i,
   .a_inv_clk_i, .a_inv_en_i, .a_inv_we_i, .a_inv_preset_i, .a_read_data_o,
   .a_read_par_o
);

// File: test/dpbr_user_port.sv
// fabric logic model driving one memory port
`timescale 1ns/1ps
module dpbr_user_port (
   input  wire        clk_i, // clock
   output reg  [3:0]  inv_o, // clk, en, we, preset inversion
   output reg         port_clk_o, // port clock pin
   output reg         en_o, // enable pin
   output reg         we_o, // write pin
   output reg         preset_o, // preset pin
   output reg  [13:0] addr_o, // address
   output reg  [31:0] data_o, // write data
   output reg  [3:0]  par_o // write parity
);
   // idle: all pins inactive, normal polarity
   initial begin
      {inv_o, port_clk_o, en_o, we_o, preset_o} = 8'h00;
      {addr_o, data_o, par_o} = 50'h0;
   end
   // new polarity and idle pins in one step, so no false edge
   task set_inv(input [3:0] v);
      begin
         @(posedge clk_i) #2;
         inv_o = v;
         {port_clk_o, en_o, we_o, preset_o} = v;
      end
   endtask
   // one access: clock inactive one sample, active the next
   task op(input e, input w, input s, input [13:0] a, input [31:0] d);
      begin
         @(posedge clk_i) #2;
         port_clk_o = inv_o[3];
         en_o = e ^ inv_o[2];
         we_o = w ^ inv_o[1];
         preset_o = s ^ inv_o[0];
         addr_o = a;
         data_o = d;
         par_o = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
         @(posedge clk_i) #2;
         port_clk_o = ~inv_o[3];
         @(posedge clk_i) #2;
         port_clk_o = inv_o[3];
         {addr_o, data_o, par_o} = ~{a, d, par_o};
         {en_o, we_o, preset_o} = inv_o[2:0];
      end
   endtask
endmodule // dpbr_user_port

// File: test/dual_port_block_ram_test.sv
// self-checking bench for the dual-port memory block
`timescale 1ns/1ps
`include "dpbr_defs.vh"
`define CHK(got, exp) \
   begin \
      samples_checked = samples_checked + 1; \
      if ((got) !== (exp)) begin \
         fails = fails + 1; \
         $display("wrong value at %0t: got %h want %h", $time, got, exp); \
      end \
   end
module dual_port_block_ram_test;
   reg         clk_i;
   reg         rst_n_i;
   reg  [2:0]  aw, bw;
   reg  [1:0]  am, bm;
   reg  [35:0] ap, bp;
   wire [3:0]  ai, bi, awp, bwp, arp, brp;
   wire        ac, ae, awe, as, bc, be, bwe, bs;
   wire [13:0] aa, ba;
   wire [31:0] awd, bwd, ard, brd;
   wire [35:0] aq = {arp, ard};
   wire [35:0] bq = {brp, brd};
   integer     fails;
   integer     samples_checked;
   dpbr_user_port i_a (.clk_i(clk_i), .inv_o(ai), .port_clk_o(ac),
      .en_o(ae), .we_o(awe), .preset_o(as), .addr_o(aa), .data_o(awd),
      .par_o(awp));
   dpbr_user_port i_b (.clk_i(clk_i), .inv_o(bi), .port_clk_o(bc),
      .en_o(be), .we_o(bwe), .preset_o(bs), .addr_o(ba), .data_o(bwd),
      .par_o(bwp));
   dpbr_top i_dpbr_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .a_port_clk_i(ac), .a_en_i(ae), .a_we_i(awe),
      .a_sync_output_set_reset_i(as), .a_addr_i(aa), .a_write_data_in_i(awd),
      .a_write_par_in_i(awp), .a_read_data_o(ard), .a_read_par_o(arp),
      .a_width_i(aw), .a_write_mode_i(am), .a_output_preset_value_i(ap),
      .a_inv_clk_i(ai[3]), .a_inv_en_i(ai[2]), .a_inv_we_i(ai[1]),
      .a_inv_preset_i(ai[0]), .b_port_clk_i(bc), .b_en_i(be), .b_we_i(bwe),
      .b_sync_output_set_reset_i(bs), .b_addr_i(ba), .b_write_data_in_i(bwd),
      .b_write_par_in_i(bwp), .b_read_data_o(brd), .b_read_par_o(brp),
      .b_width_i(bw), .b_write_mode_i(bm), .b_output_preset_value_i(bp),
      .b_inv_clk_i(bi[3]), .b_inv_en_i(bi[2]), .b_inv_we_i(bi[1]),
      .b_inv_preset_i(bi[0]));
   // full word with one parity bit per byte
   function [35:0] w36(input [31:0] d);
      w36 = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0], d};
   endfunction
   // wide write on b, read back on a
   task t_wide;
      begin
         i_b.op(1'b1, 1'b1, 1'b0, 14'h0005, 32'hdeadbeef);
         `CHK(bq, w36(32'hdeadbeef))
         i_a.op(1'b1, 1'b0, 1'b0, 14'h0005, 32'h0);
         `CHK(aq, w36(32'hdeadbeef))
      end
   endtask
   // read-first, no-change, then plain read
   task t_modes;
      begin
         am = `DPBR_RD_FIRST;
         i_a.op(1'b1, 1'b1, 1'b0, 14'h0005, 32'h12345678);
         `CHK(aq, w36(32'hdeadbeef))
         am = `DPBR_NO_CHANGE;
         i_a.op(1'b1, 1'b1, 1'b0, 14'h0005, 32'h01020304);
         `CHK(aq, w36(32'hdeadbeef))
         am = `DPBR_WR_FIRST;
         i_a.op(1'b1, 1'b0, 1'b0, 14'h0005, 32'h0);
         `CHK(aq, w36(32'h01020304))
      end
   endtask
   // narrow views of word 5 on a, wide check on b
   task t_convert;
      begin
         aw = `DPBR_W9;
         i_a.op(1'b1, 1'b0, 1'b0, 14'h0016, 32'h0);
         `CHK(aq, {4'h1, 32'h00000002})
         aw = `DPBR_W18;
         i_a.op(1'b1, 1'b0, 1'b0, 14'h000b, 32'h0);
         `CHK(aq, {4'h3, 32'h00000102})
         aw = `DPBR_W1;
         i_a.op(1'b1, 1'b0, 1'b0, 14'h00b8, 32'h0);
         `CHK(aq, {4'h0, 32'h00000001})
         aw = `DPBR_W4;
         i_a.op(1'b1, 1'b0, 1'b0, 14'h002e, 32'h0);
         `CHK(aq, {4'h0, 32'h00000001})
         aw = `DPBR_W2;
         i_a.op(1'b1, 1'b0, 1'b0, 14'h0058, 32'h0);
         `CHK(aq, {4'h0, 32'h00000002})
         aw = `DPBR_W1;
         i_a.op(1'b1, 1'b1, 1'b0, 14'h00a0, 32'h00000001);
         i_b.op(1'b1, 1'b0, 1'b0, 14'h0005, 32'h0);
         `CHK(bq, w36(32'h01020304) | 36'h1)
         aw = `DPBR_W36;
      end
   endtask
   // preset with write, disabled preset and write
   task t_preset;
      begin
         i_a.op(1'b1, 1'b1, 1'b0, 14'h0006, 32'h33333333);
         `CHK(aq, w36(32'h33333333))
         ap = 36'h9a5a5a5a5;
         i_a.op(1'b1, 1'b1, 1'b1, 14'h0006, 32'h11111111);
         `CHK(aq, 36'h9a5a5a5a5)
         ap = 36'h0;
         i_a.op(1'b0, 1'b1, 1'b1, 14'h0006, 32'h22222222);
         `CHK(aq, 36'h9a5a5a5a5)
         i_a.op(1'b1, 1'b0, 1'b0, 14'h0006, 32'h0);
         `CHK(aq, w36(32'h11111111))
      end
   endtask
   // all pins inverted on both ports
   task t_polarity;
      begin
         i_a.set_inv(4'hf);
         i_b.set_inv(4'hf);
         i_b.op(1'b1, 1'b1, 1'b0, 14'h0007, 32'hcafef00d);
         `CHK(bq, w36(32'hcafef00d))
         bm = `DPBR_NO_CHANGE;
         i_b.op(1'b1, 1'b1, 1'b0, 14'h0008, 32'h0badf00d);
         `CHK(bq, w36(32'hcafef00d))
         i_a.op(1'b1, 1'b0, 1'b0, 14'h0008, 32'h0);
         `CHK(aq, w36(32'h0badf00d))
         bp = 36'h123456789;
         i_b.op(1'b1, 1'b0, 1'b1, 14'h0007, 32'h0);
         `CHK(bq, 36'h123456789)
      end
   endtask
   task report_and_stop;
      begin
         if (fails == 0 && samples_checked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // 25 ns clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // reset, then the scenarios in turn
   initial begin
      fails = 0;
      samples_checked = 0;
      rst_n_i = 1'b0;
      {aw, bw, am, bm} = {`DPBR_W36, `DPBR_W36, `DPBR_WR_FIRST, `DPBR_WR_FIRST};
      {ap, bp} = 72'h0;
      repeat (12) @(posedge clk_i);
      #2 rst_n_i = 1'b1;
      t_wide;
      t_modes;
      t_convert;
      t_preset;
      t_polarity;
      report_and_stop;
   end
   // about 70 cycles of work, so 2000 means a hang
   initial begin
      #(25 * 2000);
      fails = fails + 1;
      report_and_stop;
   end
endmodule // dual_port_block_ram_test
